// file: hw/pss_top.sv
// How it works
// - Four stored sets exist; writing 1 to 4 to the store selector saves the working settings.
// - A load overwrites the working settings, so unsaved edits are lost.
// - After power-up reset set 1 is loaded automatically.
// - The two selection inputs form a binary code, first input low bit, code plus one is the set.
// - No more than two inputs may take the select function and extra assignments are refused.
// - The lowest-numbered select input is the low bit, the next higher one the high bit.
// - The select code is checked when the power-up load of set 1 ends, but reset clears every input function, so no other set follows.
// - A load starts when the load input goes active while inhibited, selection set beforehand.
// - The load input acts on the edge where it goes active and after a load the load selector shows the set in use.
// - For about one second after a load starts, enable is ignored and ready is withdrawn.
// - Writing the load selector loads factory defaults for 0 or sets 1 to 4, reset value 0.
// - Assigning the load function to an input that already reads active starts a load at once.
`timescale 1ns/100ps
module pss_top
  import pss_pkg::*;
#(
  parameter int NUM_IN = 8,
  parameter int NUM_PAR = 8,
  parameter int PAR_W = 16,
  parameter int LOAD_CYCLES = PSS_LOAD_CYCLES
)
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Control terminals
  input wire logic [NUM_IN-1:0] DIN,
  input wire logic INHIBIT,
  input wire logic ENABLE_IN,
  output logic READY,
  output logic ENABLE_OUT,
  // Set selector codes
  input wire logic LOAD_SEL_WR,
  input wire logic [2:0] LOAD_SEL_DATA,
  input wire logic STORE_SEL_WR,
  input wire logic [2:0] STORE_SEL_DATA,
  output logic [2:0] LOAD_SEL_Q,
  output logic [2:0] STORE_SEL_Q,
  // Input polarity and function assignment
  input wire logic POL_WR,
  input wire logic [NUM_IN-1:0] POL_DATA,
  input wire logic FUNC_WR,
  input wire logic [$clog2(NUM_IN)-1:0] FUNC_IDX,
  input wire pss_func_t FUNC_DATA,
  output logic FUNC_REJECT,
  // Working settings
  input wire logic PAR_WR,
  input wire logic [$clog2(NUM_PAR)-1:0] PAR_ADDR,
  input wire logic [PAR_W-1:0] PAR_WDATA,
  input wire logic [$clog2(NUM_PAR)-1:0] PAR_RADDR,
  output logic [PAR_W-1:0] PAR_RDATA
);
  localparam int CW = $clog2(LOAD_CYCLES + 1);

  pss_state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [2:0] pend_reg, pend_next;
  logic boot_chk_reg, boot_chk_next;
  logic trig_prev_reg, trig_prev_next;
  logic [2:0] load_sel_reg, load_sel_next;
  logic [2:0] store_sel_reg, store_sel_next;
  logic [NUM_IN-1:0] pol_reg, pol_next;
  pss_func_t func_reg [NUM_IN];
  pss_func_t func_next [NUM_IN];
  logic reject_reg, reject_next;
  logic [PAR_W-1:0] work_reg [NUM_PAR];
  logic [PAR_W-1:0] work_next [NUM_PAR];
  logic [PAR_W-1:0] set_reg [PSS_NUM_SETS][NUM_PAR];
  logic [PAR_W-1:0] set_next [PSS_NUM_SETS][NUM_PAR];
  logic ready_reg, ready_next;
  logic enable_reg, enable_next;
  logic [PAR_W-1:0] rdata_reg, rdata_next;

  logic [1:0] sel_code;
  logic load_active;
  logic trig;
  logic start;
  logic [2:0] start_code;
  int sel_count;

  pss_input_map #(.NUM_IN(NUM_IN)) u_map (
    .din(DIN),
    .pol_high(pol_reg),
    .func(func_reg),
    .sel_code(sel_code),
    .load_active(load_active)
  );

  // Only inhibited loads count; edge of the combined level avoids endless reloads
  assign trig = load_active & INHIBIT;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pend_next = pend_reg;
    boot_chk_next = boot_chk_reg;
    trig_prev_next = trig;
    load_sel_next = load_sel_reg;
    store_sel_next = store_sel_reg;
    pol_next = pol_reg;
    func_next = func_reg;
    reject_next = 1'b0;
    work_next = work_reg;
    set_next = set_reg;
    start = 1'b0;
    start_code = PSS_CODE_SET1;
    sel_count = 0;
    for (int i = 0; i < NUM_IN; i++)
      if (func_reg[i] == FN_SELECT && i != int'(FUNC_IDX))
        sel_count++;
    case (state_reg)
      ST_BOOT:
      begin
        start = 1'b1;
        start_code = PSS_CODE_SET1;
        boot_chk_next = 1'b1;
      end
      ST_IDLE:
      begin
        if (LOAD_SEL_WR && LOAD_SEL_DATA <= PSS_CODE_SET_LAST)
        begin
          start = 1'b1;
          start_code = LOAD_SEL_DATA;
        end
        else if (trig && !trig_prev_reg)
        begin
          start = 1'b1;
          start_code = {1'b0, sel_code} + 3'h1;
        end
        else if (STORE_SEL_WR && STORE_SEL_DATA >= PSS_CODE_SET1
                 && STORE_SEL_DATA <= PSS_CODE_SET_LAST)
        begin
          store_sel_next = STORE_SEL_DATA;
          set_next[2'(STORE_SEL_DATA - 3'h1)] = work_reg;
        end
        if (PAR_WR && !start)
          work_next[PAR_ADDR] = PAR_WDATA;
        if (POL_WR)
          pol_next = POL_DATA;
        if (FUNC_WR)
        begin
          if (FUNC_DATA == FN_SELECT && sel_count >= PSS_MAX_SEL_INPUTS)
            reject_next = 1'b1;
          else
            func_next[FUNC_IDX] = FUNC_DATA;
        end
      end
      ST_BUSY:
      begin
        // Every request is dropped here, not queued
        if (cnt_reg != '0)
          cnt_next = cnt_reg - CW'(1);
        else
        begin
          load_sel_next = pend_reg;
          boot_chk_next = 1'b0;
          state_next = ST_IDLE;
          if (boot_chk_reg && sel_code != 2'h0)
          begin
            start = 1'b1;
            start_code = {1'b0, sel_code} + 3'h1;
          end
        end
      end
      default:
        state_next = ST_BOOT;
    endcase
    if (start)
    begin
      state_next = ST_BUSY;
      cnt_next = CW'(LOAD_CYCLES - 1);
      pend_next = start_code;
      if (start_code == PSS_CODE_FACTORY)
        for (int p = 0; p < NUM_PAR; p++)
          work_next[p] = PAR_W'(PSS_FACTORY_WORD);
      else
        work_next = set_reg[2'(start_code - 3'h1)];
    end
    ready_next = (state_next == ST_IDLE);
    enable_next = ENABLE_IN && (state_next == ST_IDLE);
    rdata_next = work_reg[PAR_RADDR];
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      state_reg <= ST_BOOT;
      cnt_reg <= '0;
      pend_reg <= PSS_CODE_SET1;
      boot_chk_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      load_sel_reg <= PSS_LOAD_SEL_RESET;
      store_sel_reg <= PSS_STORE_SEL_RESET;
      pol_reg <= '1;
      reject_reg <= 1'b0;
      ready_reg <= 1'b0;
      enable_reg <= 1'b0;
      rdata_reg <= '0;
      for (int i = 0; i < NUM_IN; i++)
        func_reg[i] <= FN_NONE;
      for (int p = 0; p < NUM_PAR; p++)
      begin
        work_reg[p] <= PAR_W'(PSS_FACTORY_WORD);
        for (int s = 0; s < PSS_NUM_SETS; s++)
          set_reg[s][p] <= PAR_W'(PSS_FACTORY_WORD);
      end
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
      boot_chk_reg <= boot_chk_next;
      trig_prev_reg <= trig_prev_next;
      load_sel_reg <= load_sel_next;
      store_sel_reg <= store_sel_next;
      pol_reg <= pol_next;
      func_reg <= func_next;
      reject_reg <= reject_next;
      work_reg <= work_next;
      set_reg <= set_next;
      ready_reg <= ready_next;
      enable_reg <= enable_next;
      rdata_reg <= rdata_next;
    end
  end

  assign READY = ready_reg;
  assign ENABLE_OUT = enable_reg;
  assign LOAD_SEL_Q = load_sel_reg;
  assign STORE_SEL_Q = store_sel_reg;
  assign FUNC_REJECT = reject_reg;
  assign PAR_RDATA = rdata_reg;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  boot_loads_set1_a: assert property (state_reg == ST_BOOT |=>
    state_reg == ST_BUSY && pend_reg == 3'h1)
    else $error("power-up did not load set 1");
  busy_holds_off_a: assert property (state_reg == ST_BUSY |-> !READY && !ENABLE_OUT)
    else $error("ready or enable seen during load");
  busy_count_a: assert property (state_reg == ST_BUSY && cnt_reg != '0 |=>
    state_reg == ST_BUSY && cnt_reg == $past(cnt_reg) - CW'(1))
    else $error("load hold count did not step");
  busy_exit_a: assert property ($fell(state_reg == ST_BUSY) |-> $past(cnt_reg) == '0)
    else $error("load left before hold time");
  load_report_a: assert property (state_reg == ST_BUSY && cnt_reg == '0 |=>
    LOAD_SEL_Q == $past(pend_reg))
    else $error("load selector not updated");
  terminal_load_a: assert property (state_reg == ST_IDLE && !LOAD_SEL_WR
    && trig && !trig_prev_reg
    |=> state_reg == ST_BUSY && pend_reg == $past({1'b0, sel_code}) + 3'h1)
    else $error("terminal load wrong set");
  no_load_enabled_a: assert property (state_reg == ST_IDLE && !INHIBIT
    && !LOAD_SEL_WR |=> state_reg == ST_IDLE)
    else $error("load started while enabled");
  sw_load_a: assert property (state_reg == ST_IDLE && LOAD_SEL_WR
    && LOAD_SEL_DATA <= 3'h4
    |=> state_reg == ST_BUSY && pend_reg == $past(LOAD_SEL_DATA))
    else $error("selector write did not load");
  store_copy_a: assert property (state_reg == ST_IDLE && !LOAD_SEL_WR
    && !(trig && !trig_prev_reg) && STORE_SEL_WR && STORE_SEL_DATA == 3'h2
    |=> set_reg[1][0] == $past(work_reg[0]))
    else $error("store did not copy working set");
  busy_ignore_a: assert property (state_reg == ST_BUSY && cnt_reg > CW'(1) |=>
    $stable(pend_reg) && $stable(store_sel_reg))
    else $error("request acted on during load");
  sel_limit_a: assert property (state_reg == ST_IDLE && FUNC_WR
    && FUNC_DATA == FN_SELECT && sel_count >= 2 |=> FUNC_REJECT)
    else $error("third select input accepted");

  boot_second_c: cover property (boot_chk_reg && state_reg == ST_BUSY && cnt_reg == '0
    && sel_code != 2'h0);
  terminal_load_c: cover property (state_reg == ST_IDLE && trig && !trig_prev_reg);
  factory_load_c: cover property (state_reg == ST_IDLE && LOAD_SEL_WR && LOAD_SEL_DATA == 3'h0);
  reject_c: cover property (FUNC_REJECT);
endmodule

// file: hw/pss_pkg.sv
package pss_pkg;
  localparam int PSS_NUM_SETS = 4;
  localparam int PSS_MAX_SEL_INPUTS = 2;
  localparam int PSS_CLOCK_HZ = 20_000_000;
  localparam int PSS_LOAD_TIME_MS = 1000;
  // A least-kind figure is not needed here: the hold time is approximate
  localparam int PSS_LOAD_CYCLES = (PSS_CLOCK_HZ / 1000) * PSS_LOAD_TIME_MS;
  localparam logic [2:0] PSS_LOAD_SEL_RESET = 3'h0;
  localparam logic [2:0] PSS_STORE_SEL_RESET = 3'h1;
  localparam logic [2:0] PSS_CODE_FACTORY = 3'h0;
  localparam logic [2:0] PSS_CODE_SET1 = 3'h1;
  localparam logic [2:0] PSS_CODE_SET_LAST = 3'h4;
  localparam logic [15:0] PSS_FACTORY_WORD = 16'h0000;

  typedef enum logic [1:0] {FN_NONE, FN_SELECT, FN_LOAD, FN_OTHER} pss_func_t;
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_BUSY} pss_state_t;
endpackage

// file: hw/pss_input_map.sv
`timescale 1ns/100ps
module pss_input_map
  import pss_pkg::*;
#(
  parameter int NUM_IN = 8
)
(
  // Terminal levels and their configuration
  input wire logic [NUM_IN-1:0] din,
  input wire logic [NUM_IN-1:0] pol_high,
  input wire pss_func_t func [NUM_IN],
  // Decoded functions
  output logic [1:0] sel_code,
  output logic load_active
);
  logic [NUM_IN-1:0] active;
  logic found_first;
  logic found_second;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++)
    begin : g_pol
      assign active[gi] = pol_high[gi] ? din[gi] : ~din[gi];
    end
  endgenerate

  always_comb
  begin
    sel_code = 2'h0;
    load_active = 1'b0;
    found_first = 1'b0;
    found_second = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (func[i] == FN_LOAD && active[i])
        load_active = 1'b1;
      if (func[i] == FN_SELECT)
      begin
        if (!found_first)
        begin
          sel_code[0] = active[i];
          found_first = 1'b1;
        end
        else if (!found_second)
        begin
          sel_code[1] = active[i];
          found_second = 1'b1;
        end
      end
    end
  end
endmodule

// file: dv/pss_machine_ctrl.sv
`timescale 1ns/100ps
module pss_machine_ctrl
(
  // Requests from the bench
  input wire logic clk,
  input wire logic [1:0] code,
  input wire logic go,
  input wire logic inh,
  // Terminals
  output logic [7:0] din,
  output logic inhibit
);
  logic armed_reg;
  initial
  begin
    din = 8'h00;
    inhibit = 1'b1;
    armed_reg = 1'b0;
  end
  always @(posedge clk)
  begin
    armed_reg <= go;
    din[1:0] <= code;
    din[2] <= go && armed_reg;
    // Unused inputs toggle so a stale level cannot hide a decode slip
    din[7:3] <= ~din[7:3];
    inhibit <= inh;
  end
endmodule

// file: dv/test_parameter_set_switcher.sv
`timescale 1ns/100ps
module test_parameter_set_switcher
  import pss_pkg::*;
();
  localparam int LC = 16;
  logic clk, rst, en_in, ld_wr, st_wr, pol_wr, fn_wr, par_wr, go, inh;
  logic [2:0] ld_d, st_d, fn_idx, par_a, par_ra, ld_q, st_q, exp_ld, exp_st;
  logic [7:0] din, pol_d;
  logic [1:0] code;
  logic [15:0] par_wd, rdata;
  logic ready, en_out, fn_rej, inhibit;
  pss_func_t fn_d;
  logic [15:0] work [8];
  logic [15:0] sets [4][8];
  logic [31:0] seed, r;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;

  pss_top #(.NUM_IN(8), .LOAD_CYCLES(LC)) uut (
    .CLOCK(clk), .SYS_RST(rst), .DIN(din), .INHIBIT(inhibit), .ENABLE_IN(en_in),
    .READY(ready), .ENABLE_OUT(en_out), .LOAD_SEL_WR(ld_wr), .LOAD_SEL_DATA(ld_d),
    .STORE_SEL_WR(st_wr), .STORE_SEL_DATA(st_d), .LOAD_SEL_Q(ld_q), .STORE_SEL_Q(st_q),
    .POL_WR(pol_wr), .POL_DATA(pol_d), .FUNC_WR(fn_wr), .FUNC_IDX(fn_idx),
    .FUNC_DATA(fn_d), .FUNC_REJECT(fn_rej), .PAR_WR(par_wr), .PAR_ADDR(par_a),
    .PAR_WDATA(par_wd), .PAR_RADDR(par_ra), .PAR_RDATA(rdata));
  pss_machine_ctrl mc (.clk(clk), .code(code), .go(go), .inh(inh), .din(din),
    .inhibit(inhibit));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Ceiling is several times the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      fail_count++;
      finish_test();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    check(16'(ld_q), 16'(exp_ld));
    check(16'(st_q), 16'(exp_st));
    check(16'(ready), 16'h0001);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      par_ra <= i[2:0];
      @(posedge clk);
      #1;
      check(rdata, work[i]);
    end
  endtask

  // A store is held up for the whole load because it must be dropped
  task automatic ride_load();
    int n;
    n = 0;
    en_in <= 1'b1;
    for (int t = 0; t < LC + 12; t++)
    begin
      @(posedge clk);
      #1;
      // A selector write stands until the first edge in here has taken it
      ld_wr <= 1'b0;
      if (ready === 1'b0)
      begin
        n++;
        st_wr <= 1'b1;
        st_d <= 3'h4;
        check(16'(en_out), 16'h0000);
      end
      else if (n > 0)
        break;
    end
    st_wr <= 1'b0;
    check(16'(n), 16'(LC));
    @(posedge clk);
    #1;
    check(16'(en_out), 16'h0001);
    en_in <= 1'b0;
  endtask

  task automatic take(input logic [2:0] s);
    exp_ld = s;
    foreach (work[i])
      work[i] = (s == 3'h0) ? 16'h0000 : sets[s - 3'h1][i];
    check_all();
  endtask

  task automatic par_put(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    par_wr <= 1'b1;
    par_a <= a;
    par_wd <= d;
    @(posedge clk);
    par_wr <= 1'b0;
    work[a] = d;
  endtask

  task automatic store(input logic [2:0] c);
    @(posedge clk);
    st_wr <= 1'b1;
    st_d <= c;
    @(posedge clk);
    st_wr <= 1'b0;
    if (c >= 3'h1 && c <= 3'h4)
    begin
      exp_st = c;
      foreach (work[i])
        sets[c - 3'h1][i] = work[i];
    end
  endtask

  task automatic sw_load(input logic [2:0] c);
    @(posedge clk);
    ld_wr <= 1'b1;
    ld_d <= c;
    if (c <= 3'h4)
    begin
      // The load starts on the first edge of the ride, so every busy cycle is counted
      ride_load();
      take(c);
    end
    else
    begin
      @(posedge clk);
      ld_wr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check_all();
    end
  endtask

  task automatic term_load(input logic [1:0] k);
    code <= k;
    @(posedge clk);
    go <= 1'b1;
    ride_load();
    go <= 1'b0;
    take(3'(k) + 3'h1);
  endtask

  task automatic assign_fn(input logic [2:0] i, input pss_func_t f, input logic rej);
    @(posedge clk);
    fn_wr <= 1'b1;
    fn_idx <= i;
    fn_d <= f;
    @(posedge clk);
    fn_wr <= 1'b0;
    #1;
    check(16'(fn_rej), 16'(rej));
  endtask

  task automatic pol_put(input logic [7:0] p);
    @(posedge clk);
    pol_wr <= 1'b1;
    pol_d <= p;
    @(posedge clk);
    pol_wr <= 1'b0;
  endtask

  initial
  begin
    {en_in, ld_wr, st_wr, pol_wr, fn_wr, par_wr, go, code} = '0;
    {ld_d, st_d, fn_idx, par_a, par_ra, pol_d, par_wd} = '0;
    fn_d = FN_NONE;
    rst = 1'b1;
    inh = 1'b1;
    seed = 32'h00008A8F;
    exp_ld = 3'h0;
    exp_st = 3'h1;
    foreach (sets[i, j])
      sets[i][j] = 16'h0000;
    foreach (work[i])
      work[i] = 16'h0000;
    repeat (20) @(posedge clk);
    #1;
    check(16'(ready), 16'h0000);
    check(16'(st_q), 16'h0001);
    check(16'(ld_q), 16'h0000);
    rst <= 1'b0;
    r = 32'h00000000;
    while (ready !== 1'b1 && r < 32'h00000064)
    begin
      @(posedge clk);
      #1;
      r++;
    end
    // One edge to leave the boot state, then the full hold
    check(r[15:0], 16'(LC + 1));
    take(3'h1);
    assign_fn(3'h0, FN_SELECT, 1'b0);
    assign_fn(3'h1, FN_SELECT, 1'b0);
    assign_fn(3'h3, FN_SELECT, 1'b1);
    assign_fn(3'h2, FN_LOAD, 1'b0);
    pol_put(8'hFB);
    ride_load();
    take(3'h1);
    pol_put(8'hFF);
    inh <= 1'b0;
    code <= 2'h3;
    repeat (3) @(posedge clk);
    go <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check(16'(ready), 16'h0001);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    inh <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      par_put(i[2:0], r[15:0]);
      store(3'(i + 1));
    end
    for (int c = 0; c < 8; c++)
    begin
      r = xs();
      par_put(r[2:0], r[31:16]);
      sw_load(c[2:0]);
    end
    for (int k = 0; k < 4; k++)
      term_load(k[1:0]);
    for (int n = 0; n < 40; n++)
    begin
      r = xs();
      case (r[1:0])
        2'h0: par_put(r[4:2], r[31:16]);
        2'h1: store(r[7:5]);
        2'h2: sw_load(r[10:8]);
        default: term_load(r[12:11]);
      endcase
    end
    finish_test();
  end
endmodule
